// ===== core/card_link.sv
`timescale 1ns/1ps
`include "card_consts.svh"
module card_link #(
	parameter int FRAME_BITS = `CARD_FRAME_BITS,
	parameter int RX_BITS    = `CARD_RX_BITS
) (
	input  wire logic       link_clk,
	input  wire logic       presetn,
	card_link_if.link       lk,
	input  wire logic       io_i,
	output logic            io_o,
	output logic            io_oe
);
	card_pkg::link_state_e state_r;
	logic [1:0]            txon_s;
	logic [1:0]            rxon_s;
	logic [1:0]            io_s;
	logic [1:0]            req_s;
	logic                  req_seen_r;
	logic                  ack_r;
	logic                  rtgl_r;
	logic                  fer_r;
	logic                  per_r;
	card_pkg::byte_t       rdat_r;
	logic [3:0]            cnt_r;
	logic [10:0]           sh_r;
	logic [10:0]           rsh;

	assign lk.tx_ack  = ack_r;
	assign lk.rx_tgl  = rtgl_r;
	assign lk.rx_fer  = fer_r;
	assign lk.rx_per  = per_r;
	assign lk.rx_data = rdat_r;
	assign rsh        = {io_s[1], sh_r[10:1]};

	// ==========================================================================
	// Crossings into the link domain
	always_ff @(posedge link_clk or negedge presetn) begin
		if (!presetn) begin
			txon_s <= 2'h0;
			rxon_s <= 2'h0;
			io_s   <= 2'h3;
			req_s  <= 2'h0;
		end else begin
			txon_s <= {txon_s[0], lk.tx_on};
			rxon_s <= {rxon_s[0], lk.rx_on};
			io_s   <= {io_s[0], io_i};
			req_s  <= {req_s[0], lk.tx_req};
		end
	end

	// ==========================================================================
	// Frame engine, one bit per link clock, even parity
	always_ff @(posedge link_clk or negedge presetn) begin
		if (!presetn) begin
			state_r    <= card_pkg::LK_IDLE;
			req_seen_r <= 1'b0;
			ack_r      <= 1'b0;
			rtgl_r     <= 1'b0;
			fer_r      <= 1'b0;
			per_r      <= 1'b0;
			rdat_r     <= 8'h00;
			cnt_r      <= 4'h0;
			sh_r       <= 11'h7FF;
			io_o       <= 1'b1;
			io_oe      <= 1'b0;
		end else begin
			case (state_r)
				card_pkg::LK_IDLE: begin
					io_o  <= 1'b1;
					io_oe <= 1'b0;
					cnt_r <= 4'h0;
					// Always acknowledged so the control side never hangs on a stale request
					if (req_s[1] != req_seen_r) begin
						req_seen_r <= req_s[1];
						ack_r      <= ~ack_r;
						if (txon_s[1]) begin
							sh_r    <= {1'b1, ^lk.tx_data, lk.tx_data, 1'b0};
							state_r <= card_pkg::LK_TX;
						end
					end else if (rxon_s[1] && !io_s[1]) begin
						state_r <= card_pkg::LK_RX;
					end
				end
				card_pkg::LK_TX: begin
					io_oe <= 1'b1;
					io_o  <= sh_r[0];
					sh_r  <= {1'b1, sh_r[10:1]};
					cnt_r <= cnt_r + 4'h1;
					if (cnt_r == 4'(FRAME_BITS - 1))
						state_r <= card_pkg::LK_IDLE;
				end
				card_pkg::LK_RX: begin
					sh_r  <= rsh;
					cnt_r <= cnt_r + 4'h1;
					if (cnt_r == 4'(RX_BITS - 1)) begin
						rdat_r  <= rsh[8:1];
						per_r   <= ^rsh[9:1];
						fer_r   <= ~rsh[10];
						rtgl_r  <= ~rtgl_r;
						state_r <= card_pkg::LK_IDLE;
					end
				end
				default: state_r <= card_pkg::LK_IDLE;
			endcase
		end
	end

	rx_start_a: assert property (@(posedge link_clk) disable iff (!presetn)
		(state_r == card_pkg::LK_IDLE && rxon_s[1] && !io_s[1] && req_s[1] == req_seen_r)
		|=> state_r == card_pkg::LK_RX)
		else $error("start bit did not begin reception");
endmodule : card_link

// ===== core/card_serial_ctrl.sv
`timescale 1ns/1ps
`include "card_consts.svh"
module card_serial_ctrl #(
	parameter int SCK_HALF = `CARD_SCK_HALF
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        link_clk,
	input  wire logic        io_i,
	output logic             io_o,
	output logic             io_oe,
	output logic             sck_o,
	output logic             sck_oe,
	output logic             tx_empty_irq,
	output logic             rx_full_irq,
	output logic             rx_error_irq
);
	// ==========================================================================
	// Declarations
	card_link_if     lk ();
	logic [7:0]      serial_mode_r;
	logic [7:0]      serial_control_r;
	logic [7:0]      ctrl_nxt;
	card_pkg::byte_t tx_holding_r;
	card_pkg::byte_t rx_data_r;
	logic            tx_buf_empty_flag_r;
	logic            rx_buf_full_flag_r;
	logic            overrun_flag_r;
	logic            fer_r;
	logic            per_r;
	logic            tx_buf_empty_flag_nxt;
	logic            rx_buf_full_flag_nxt;
	logic            overrun_flag_nxt;
	logic            fer_nxt;
	logic            per_nxt;
	logic [4:0]      arm_r;
	logic            pending_r;
	logic            req_r;
	logic [2:0]      ack_s;
	logic [2:0]      rx_s;
	logic            ack_edge;
	logic            rx_edge;
	logic            setup_acc;
	logic            acc;
	logic            wr_fire;
	logic            rd_fire;
	logic            stat_wr;
	logic            mapped;
	logic [7:0]      rd_val;
	logic [7:0]      sck_cnt_r;
	logic            sck_div_r;

	function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
		hit = (a == o);
	endfunction : hit

	// Clear only if software saw the flag at 1 on its last status read
	function automatic logic clr_ok(input logic armed, input logic wbit);
		clr_ok = armed & ~wbit;
	endfunction : clr_ok

	card_link #(
		.FRAME_BITS (`CARD_FRAME_BITS),
		.RX_BITS    (`CARD_RX_BITS)
	) u_link (
		.link_clk (link_clk),
		.presetn  (presetn),
		.lk       (lk),
		.io_i     (io_i),
		.io_o     (io_o),
		.io_oe    (io_oe)
	);

	assign lk.tx_data = tx_holding_r;
	assign lk.tx_req  = req_r;
	assign lk.tx_on   = serial_control_r[`CARD_CTL_TE];
	assign lk.rx_on   = serial_control_r[`CARD_CTL_RE];

	// ==========================================================================
	// APB slave, one wait state so every answer comes from a flop
	assign setup_acc = psel & penable & ~pready;
	assign acc       = psel & penable & pready;
	assign wr_fire   = acc & pwrite;
	assign rd_fire   = acc & ~pwrite;
	assign stat_wr   = wr_fire & hit(paddr, `CARD_OFS_STAT);
	assign mapped    = hit(paddr, `CARD_OFS_MODE) | hit(paddr, `CARD_OFS_CTRL)
		| hit(paddr, `CARD_OFS_THR) | hit(paddr, `CARD_OFS_STAT) | hit(paddr, `CARD_OFS_RDR);

	always_comb begin
		rd_val = 8'h00;
		case (paddr)
			`CARD_OFS_MODE: rd_val = serial_mode_r;
			`CARD_OFS_CTRL: rd_val = serial_control_r;
			`CARD_OFS_THR:  rd_val = tx_holding_r;
			`CARD_OFS_STAT: rd_val = {tx_buf_empty_flag_r, rx_buf_full_flag_r, overrun_flag_r, fer_r, per_r,
				tx_buf_empty_flag_r & ~pending_r, 2'h0};
			`CARD_OFS_RDR:  rd_val = rx_data_r;
			default:        rd_val = 8'h00;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= setup_acc;
			pslverr <= setup_acc & ~mapped;
			prdata  <= (setup_acc & ~pwrite) ? {24'h00_0000, rd_val} : 32'h0000_0000;
		end
	end

	// ==========================================================================
	// Software registers
	always_comb begin
		ctrl_nxt = serial_control_r;
		if (wr_fire && hit(paddr, `CARD_OFS_CTRL))
			ctrl_nxt = pwdata[7:0];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			serial_control_r <= `CARD_CTRL_RST;
			serial_mode_r    <= `CARD_MODE_RST;
			tx_holding_r     <= 8'h00;
		end else begin
			serial_control_r <= ctrl_nxt;
			if (wr_fire && hit(paddr, `CARD_OFS_MODE))
				serial_mode_r <= pwdata[7:0];
			if (wr_fire && hit(paddr, `CARD_OFS_THR))
				tx_holding_r <= pwdata[7:0];
		end
	end

	// Arm on the value the read returned, disarm on any status write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			arm_r <= 5'h00;
		else if (rd_fire && hit(paddr, `CARD_OFS_STAT))
			arm_r <= prdata[7:3];
		else if (stat_wr)
			arm_r <= 5'h00;
	end

	// ==========================================================================
	// Event crossings from the link; stage 0 feeds stage 1 only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_s <= 3'h0;
			rx_s  <= 3'h0;
		end else begin
			ack_s <= {ack_s[1:0], lk.tx_ack};
			rx_s  <= {rx_s[1:0], lk.rx_tgl};
		end
	end
	assign ack_edge = ack_s[2] ^ ack_s[1];
	assign rx_edge  = rx_s[2] ^ rx_s[1];

	// ==========================================================================
	// Status flags; hardware set wins over software clear
	always_comb begin
		tx_buf_empty_flag_nxt = tx_buf_empty_flag_r;
		rx_buf_full_flag_nxt = rx_buf_full_flag_r;
		overrun_flag_nxt = overrun_flag_r;
		fer_nxt  = fer_r;
		per_nxt  = per_r;
		if (!serial_control_r[`CARD_CTL_TE])
			tx_buf_empty_flag_nxt = 1'b1;
		else if (ack_edge)
			tx_buf_empty_flag_nxt = 1'b1;
		else if (stat_wr && clr_ok(arm_r[4], pwdata[`CARD_ST_TX_BUF_EMPTY_FLAG]))
			tx_buf_empty_flag_nxt = 1'b0;
		// Receive enable plays no part here, so flags survive it turning off
		if (rx_edge && !rx_buf_full_flag_r && !lk.rx_fer && !lk.rx_per)
			rx_buf_full_flag_nxt = 1'b1;
		else if (stat_wr && clr_ok(arm_r[3], pwdata[`CARD_ST_RX_BUF_FULL_FLAG]))
			rx_buf_full_flag_nxt = 1'b0;
		if (rx_edge && rx_buf_full_flag_r)
			overrun_flag_nxt = 1'b1;
		else if (stat_wr && clr_ok(arm_r[2], pwdata[`CARD_ST_OVERRUN_FLAG]))
			overrun_flag_nxt = 1'b0;
		if (rx_edge && !rx_buf_full_flag_r && lk.rx_fer)
			fer_nxt = 1'b1;
		else if (stat_wr && clr_ok(arm_r[1], pwdata[`CARD_ST_FER]))
			fer_nxt = 1'b0;
		if (rx_edge && !rx_buf_full_flag_r && lk.rx_per)
			per_nxt = 1'b1;
		else if (stat_wr && clr_ok(arm_r[0], pwdata[`CARD_ST_PER]))
			per_nxt = 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_buf_empty_flag_r <= 1'b1;
			rx_buf_full_flag_r <= 1'b0;
			overrun_flag_r <= 1'b0;
			fer_r  <= 1'b0;
			per_r  <= 1'b0;
		end else begin
			tx_buf_empty_flag_r <= tx_buf_empty_flag_nxt;
			rx_buf_full_flag_r <= rx_buf_full_flag_nxt;
			overrun_flag_r <= overrun_flag_nxt;
			fer_r  <= fer_nxt;
			per_r  <= per_nxt;
		end
	end

	// Overrun drops the new character: the unread one stays
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			rx_data_r <= 8'h00;
		else if (rx_edge && !rx_buf_full_flag_r)
			rx_data_r <= lk.rx_data;
	end

	// ==========================================================================
	// Transmit hand-off; holding register must stay put until the empty flag returns
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pending_r <= 1'b0;
			req_r     <= 1'b0;
		end else if (serial_control_r[`CARD_CTL_TE] && !tx_buf_empty_flag_r && !pending_r) begin
			pending_r <= 1'b1;
			req_r     <= ~req_r;
		end else if (ack_edge) begin
			pending_r <= 1'b0;
		end
	end

	// ==========================================================================
	// Interrupt request levels, built from next values to match the flags
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_empty_irq <= 1'b0;
			rx_full_irq  <= 1'b0;
			rx_error_irq <= 1'b0;
		end else begin
			tx_empty_irq <= ctrl_nxt[`CARD_CTL_TIE] & tx_buf_empty_flag_nxt;
			rx_full_irq  <= ctrl_nxt[`CARD_CTL_RIE] & rx_buf_full_flag_nxt;
			rx_error_irq <= ctrl_nxt[`CARD_CTL_RIE] & (overrun_flag_nxt | fer_nxt | per_nxt);
		end
	end

	// ==========================================================================
	// Card clock pin; divider runs free so GSM switching never waits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sck_cnt_r <= 8'h00;
			sck_div_r <= 1'b0;
		end else if (sck_cnt_r == 8'(SCK_HALF - 1)) begin
			sck_cnt_r <= 8'h00;
			sck_div_r <= ~sck_div_r;
		end else begin
			sck_cnt_r <= sck_cnt_r + 8'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sck_o  <= 1'b0;
			sck_oe <= 1'b0;
		end else begin
			case ({serial_mode_r[`CARD_MODE_GSM], serial_control_r[1:0]})
				3'h0: begin sck_oe <= 1'b0; sck_o <= 1'b0;      end
				3'h1: begin sck_oe <= 1'b1; sck_o <= sck_div_r; end
				3'h4: begin sck_oe <= 1'b1; sck_o <= 1'b0;      end
				3'h5: begin sck_oe <= 1'b1; sck_o <= sck_div_r; end
				3'h6: begin sck_oe <= 1'b1; sck_o <= 1'b1;      end
				3'h7: begin sck_oe <= 1'b1; sck_o <= sck_div_r; end
				default: begin sck_oe <= 1'b0; sck_o <= 1'b0;   end
			endcase
		end
	end

	// ==========================================================================
	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	tx_irq_gate_a: assert property (!serial_control_r[`CARD_CTL_TIE] |-> !tx_empty_irq)
		else $error("transmit request raised while disabled");
	tx_cancel_a: assert property ((stat_wr && arm_r[4] && !pwdata[`CARD_ST_TX_BUF_EMPTY_FLAG]
		&& serial_control_r[`CARD_CTL_TE] && !ack_edge) |=> !tx_empty_irq && !tx_buf_empty_flag_r)
		else $error("transmit request not withdrawn by flag clear");
	rx_irq_gate_a: assert property (!serial_control_r[`CARD_CTL_RIE]
		|-> !rx_full_irq && !rx_error_irq)
		else $error("receive request raised while disabled");
	rx_cancel_a: assert property ((stat_wr && arm_r[3] && !pwdata[`CARD_ST_RX_BUF_FULL_FLAG]
		&& !rx_edge) |=> !rx_buf_full_flag_r && !rx_full_irq)
		else $error("receive request not withdrawn by flag clear");
	tx_start_a: assert property ((serial_control_r[`CARD_CTL_TE] && $fell(tx_buf_empty_flag_r)
		&& !pending_r) |=> pending_r && $changed(req_r))
		else $error("transmission not requested");
	tx_empty_hold_a: assert property (!serial_control_r[`CARD_CTL_TE] |=> tx_buf_empty_flag_r)
		else $error("empty flag not held while transmit off");
	rx_flags_keep_a: assert property (($fell(serial_control_r[`CARD_CTL_RE]) && !rx_edge
		&& !stat_wr) |=> $stable({rx_buf_full_flag_r, overrun_flag_r, fer_r, per_r}))
		else $error("receive flags moved when receive turned off");
	sck_port_a: assert property ((!serial_mode_r[`CARD_MODE_GSM]
		&& serial_control_r[1:0] == 2'h0) |=> !sck_oe)
		else $error("clock pin driven in port mode");
	sck_high_a: assert property ((serial_mode_r[`CARD_MODE_GSM]
		&& serial_control_r[1:0] == 2'h2) |=> sck_oe && sck_o)
		else $error("clock pin not fixed high");
	sck_switch_a: assert property ((serial_mode_r[`CARD_MODE_GSM]
		&& $changed(serial_control_r[1:0]) && serial_control_r[1:0] == 2'h0)
		|=> sck_oe && !sck_o)
		else $error("clock pin did not switch to low at once");
	tx_moved_a: assert property ((ack_edge && serial_control_r[`CARD_CTL_TE])
		|=> tx_buf_empty_flag_r && !pending_r)
		else $error("empty flag not set on hand-off");
	rx_full_a: assert property ((rx_edge && !rx_buf_full_flag_r && !lk.rx_fer && !lk.rx_per)
		|=> rx_buf_full_flag_r && rx_data_r == $past(lk.rx_data))
		else $error("clean character not stored");
	irq_level_a: assert property (rx_full_irq == (serial_control_r[`CARD_CTL_RIE]
		&& rx_buf_full_flag_r))
		else $error("receive request level mismatch");
endmodule : card_serial_ctrl

// ===== include/card_consts.svh
`ifndef CARD_CONSTS_SVH
`define CARD_CONSTS_SVH
// ==========================================================================

// ==========================================================================
// Register offsets
`define CARD_OFS_MODE   12'h000
`define CARD_OFS_CTRL   12'h004
`define CARD_OFS_THR    12'h008
`define CARD_OFS_STAT   12'h00C
`define CARD_OFS_RDR    12'h010

// ==========================================================================
// Field positions
`define CARD_CTL_TIE    7
`define CARD_CTL_RIE    6
`define CARD_CTL_TE     5
`define CARD_CTL_RE     4
`define CARD_ST_TX_BUF_EMPTY_FLAG    7
`define CARD_ST_RX_BUF_FULL_FLAG    6
`define CARD_ST_OVERRUN_FLAG    5
`define CARD_ST_FER     4
`define CARD_ST_PER     3
`define CARD_ST_TEND    2
`define CARD_MODE_GSM   7

// ==========================================================================
// Reset values and counts
`define CARD_CTRL_RST   8'h00
`define CARD_MODE_RST   8'h00
`define CARD_SCK_HALF   4
`define CARD_FRAME_BITS 11
`define CARD_RX_BITS    10
`endif

// ===== include/card_link_if.sv
`timescale 1ns/1ps
interface card_link_if;
	card_pkg::byte_t tx_data;
	logic            tx_req;
	logic            tx_ack;
	logic            tx_on;
	logic            rx_on;
	card_pkg::byte_t rx_data;
	logic            rx_fer;
	logic            rx_per;
	logic            rx_tgl;
	modport ctl  (output tx_data, tx_req, tx_on, rx_on, input tx_ack, rx_data, rx_fer, rx_per,
		rx_tgl);
	modport link (input tx_data, tx_req, tx_on, rx_on, output tx_ack, rx_data, rx_fer, rx_per,
		rx_tgl);
endinterface : card_link_if

// ===== include/card_pkg.sv
package card_pkg;
	typedef logic [7:0] byte_t;
	typedef enum {LK_IDLE, LK_TX, LK_RX} link_state_e;
endpackage : card_pkg

// ===== tb/card_model.sv
`timescale 1ns/1ps
// ==========================================================================
// Card side of the data line
module card_model (
	input  wire logic       link_clk,
	input  wire logic       io_line,
	output logic            card_o,
	output logic            card_oe,
	output card_pkg::byte_t got,
	output logic            got_ok,
	output logic            got_stb
);
	logic [9:0] sh_r;
	logic [9:0] full;
	int         cnt_r;
	assign full = {io_line, sh_r[9:1]};
	initial begin
		card_o  = 1'b1;
		card_oe = 1'b0;
		got     = 8'h00;
		got_ok  = 1'b0;
		got_stb = 1'b0;
		sh_r    = 10'h000;
		cnt_r   = 0;
	end
	// Frame from the block: start 0, data LSB first, even parity, stop 1
	always @(posedge link_clk) begin
		got_stb <= 1'b0;
		if (cnt_r == 0) begin
			if (!card_oe && !io_line)
				cnt_r <= 1;
		end else begin
			sh_r  <= full;
			cnt_r <= cnt_r + 1;
			if (cnt_r == 10) begin
				got     <= full[7:0];
				got_ok  <= ~^full[8:0] & full[9];
				got_stb <= 1'b1;
				cnt_r   <= 0;
			end
		end
	end
	// Frame towards the block; faults only where the caller asks for them
	task automatic send_char(input card_pkg::byte_t d, input logic bad_par, input logic bad_stop);
		logic [10:0] f;
		f = {~bad_stop, ^d ^ bad_par, d, 1'b0};
		for (int i = 0; i < 11; i++) begin
			@(posedge link_clk);
			card_oe <= 1'b1;
			card_o  <= f[i];
		end
		@(posedge link_clk);
		card_oe <= 1'b0;
		card_o  <= ~f[10];
	endtask : send_char
endmodule : card_model

// ===== tb/smart_card_serial_control_bench.sv
`timescale 1ns/1ps
`include "card_consts.svh"
module smart_card_serial_control_bench;
	localparam int         HALF  = 4;
	localparam logic [7:0] TIE_B = 8'h01 << `CARD_CTL_TIE;
	localparam logic [7:0] RIE_B = 8'h01 << `CARD_CTL_RIE;
	localparam logic [7:0] TE_B  = 8'h01 << `CARD_CTL_TE;
	localparam logic [7:0] RE_B  = 8'h01 << `CARD_CTL_RE;
	typedef struct {logic [31:0] d; logic [31:0] m; logic e;} note_s;
	logic            pclk, presetn, psel, penable, pwrite, link_clk;
	logic [11:0]     paddr;
	logic [31:0]     pwdata, prdata;
	logic            pready, pslverr, io_o, io_oe, sck_o, sck_oe, io_line;
	logic            tx_empty_irq, rx_full_irq, rx_error_irq, card_o, card_oe, got_ok, got_stb;
	logic [2:0]      irqs;
	card_pkg::byte_t got, d;
	note_s           cur;
	note_s           rd_q[$];
	card_pkg::byte_t tx_q[$];
	int              failures, samples_checked, seed, tg, ck;
	logic            lv, eo, el;
	assign irqs = {rx_error_irq, rx_full_irq, tx_empty_irq};
	// Data line has a pull-up, so a released line reads 1
	assign io_line = io_oe ? io_o : (card_oe ? card_o : 1'b1);
	card_serial_ctrl #(.SCK_HALF(HALF)) u_card_serial_ctrl (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.link_clk(link_clk), .io_i(io_line), .io_o(io_o), .io_oe(io_oe), .sck_o(sck_o),
		.sck_oe(sck_oe), .tx_empty_irq(tx_empty_irq), .rx_full_irq(rx_full_irq),
		.rx_error_irq(rx_error_irq));
	card_model u_card_model (.link_clk(link_clk), .io_line(io_line), .card_o(card_o),
		.card_oe(card_oe), .got(got), .got_ok(got_ok), .got_stb(got_stb));
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	initial begin
		link_clk = 1'b0;
		#37.3;
		forever #62.5 link_clk = ~link_clk;
	end
	// ==========================================================================
	// Checking and closing
	task automatic chk(input logic [31:0] act, input logic [31:0] exp, input string w);
		samples_checked++;
		if (act !== exp) begin
			failures++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, w, act, exp);
		end
	endtask : chk
	task automatic tally_and_finish;
		$display("checked %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : tally_and_finish
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1) begin
			if (rd_q.size() == 0) begin
				chk(32'h1, 32'h0, "answer without request");
			end else begin
				cur = rd_q.pop_front();
				chk(prdata & cur.m, cur.d, "read data");
				chk({31'h0, pslverr}, {31'h0, cur.e}, "slave error");
			end
		end
	end
	// An empty queue here means the block sent a frame nobody asked for
	always @(posedge link_clk) begin
		if (got_stb === 1'b1) begin
			if (tx_q.size() == 0)
				chk(32'h1, 32'h0, "card byte unasked");
			else
				chk({24'h0, got}, {24'h0, tx_q.pop_front()}, "card byte");
			chk({31'h0, got_ok}, 32'h1, "card frame");
		end
	end
	// ==========================================================================
	// Bus and waiting
	task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] wd,
		input logic [7:0] ex, input logic [7:0] m, input logic er);
		note_s n;
		n.d = {24'h0, ex};
		n.m = wr ? 32'h0 : {24'hFFFFFF, m};
		n.e = er;
		rd_q.push_back(n);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= {24'h0, wd};
		@(posedge pclk);
		penable <= 1'b1;
		for (int i = 0; i <= 20; i++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
			if (i == 20) begin
				failures++;
				tally_and_finish();
			end
		end
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [7:0] wd);
		apb(1'b1, a, wd, 8'h00, 8'h00, 1'b0);
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [7:0] ex, input logic [7:0] m);
		apb(1'b0, a, 8'h00, ex, m, 1'b0);
	endtask : rd
	task automatic wait_irq(input int k, input logic v);
		for (int i = 0; i <= 3000; i++) begin
			@(posedge pclk);
			if (irqs[k] === v)
				break;
			if (i == 3000) begin
				failures++;
				tally_and_finish();
			end
		end
	endtask : wait_irq
	// Requests follow flags within the edge; three cycles leave slack
	task automatic see_irq(input int k, input logic v);
		repeat (3) @(posedge pclk);
		chk({31'h0, irqs[k]}, {31'h0, v}, "request level");
	endtask : see_irq
	initial begin
		#400us;
		failures++;
		tally_and_finish();
	end
	// ==========================================================================
	// Main sequence
	initial begin
		seed = 30305;
		failures = 0;
		samples_checked = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		// Reset is asynchronous, so the link side needs no edges of its own here
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		rd(`CARD_OFS_CTRL, 8'h00, 8'hFF);
		rd(`CARD_OFS_MODE, 8'h00, 8'hFF);
		rd(`CARD_OFS_STAT, 8'h84, 8'hFF);
		apb(1'b0, 12'h020, 8'h00, 8'h00, 8'hFF, 1'b1);
		apb(1'b1, 12'h020, 8'hFF, 8'h00, 8'h00, 1'b1);
		$display("test reset done");
		wr(`CARD_OFS_CTRL, TIE_B);
		see_irq(0, 1'b1);
		rd(`CARD_OFS_STAT, 8'h80, 8'h80);
		wr(`CARD_OFS_STAT, 8'h00);
		rd(`CARD_OFS_STAT, 8'h80, 8'h80);
		wr(`CARD_OFS_CTRL, 8'h00);
		see_irq(0, 1'b0);
		$display("test transmit request done");
		wr(`CARD_OFS_MODE, 8'h00);
		wr(`CARD_OFS_CTRL, TIE_B | TE_B);
		// Writing 1 leaves the armed empty flag alone, so no frame may start
		wr(`CARD_OFS_STAT, 8'h80);
		see_irq(0, 1'b1);
		for (int k = 0; k < 3; k++) begin
			d = 8'($random(seed));
			tx_q.push_back(d);
			wr(`CARD_OFS_THR, d);
			rd(`CARD_OFS_STAT, 8'h80, 8'h80);
			wr(`CARD_OFS_STAT, 8'h00);
			see_irq(0, 1'b0);
			wait_irq(0, 1'b1);
		end
		for (int i = 0; i < 3000 && tx_q.size() > 0; i++)
			@(posedge pclk);
		chk(tx_q.size(), 32'h0, "frames sent");
		wr(`CARD_OFS_CTRL, TE_B);
		see_irq(0, 1'b0);
		$display("test transmit done");
		wr(`CARD_OFS_MODE, 8'h00);
		wr(`CARD_OFS_CTRL, RIE_B | RE_B);
		d = 8'($random(seed));
		u_card_model.send_char(d, 1'b0, 1'b0);
		wait_irq(1, 1'b1);
		rd(`CARD_OFS_RDR, d, 8'hFF);
		u_card_model.send_char(~d, 1'b0, 1'b0);
		wait_irq(2, 1'b1);
		rd(`CARD_OFS_RDR, d, 8'hFF);
		rd(`CARD_OFS_STAT, 8'h60, 8'h78);
		wr(`CARD_OFS_STAT, 8'h80);
		see_irq(1, 1'b0);
		see_irq(2, 1'b0);
		u_card_model.send_char(d, 1'b1, 1'b0);
		wait_irq(2, 1'b1);
		rd(`CARD_OFS_STAT, 8'h08, 8'h78);
		wr(`CARD_OFS_CTRL, RE_B);
		see_irq(2, 1'b0);
		wr(`CARD_OFS_CTRL, 8'h00);
		rd(`CARD_OFS_STAT, 8'h08, 8'h78);
		wr(`CARD_OFS_CTRL, RIE_B | RE_B);
		see_irq(2, 1'b1);
		wr(`CARD_OFS_STAT, 8'h80);
		see_irq(2, 1'b0);
		u_card_model.send_char(d, 1'b0, 1'b1);
		wait_irq(2, 1'b1);
		rd(`CARD_OFS_STAT, 8'h10, 8'h78);
		wr(`CARD_OFS_STAT, 8'h80);
		see_irq(2, 1'b0);
		$display("test receive done");
		// Field walked while the pin runs, without stopping it between steps
		for (int g = 0; g < 2; g++) begin
			for (int f = 0; f < 4; f++) begin
				wr(`CARD_OFS_MODE, {g[0], 7'h00});
				wr(`CARD_OFS_CTRL, {6'h00, f[1:0]});
				ck = (f == 1 || (g == 1 && f == 3)) ? 1 : 0;
				eo = (ck == 1 || g == 1);
				el = (f == 2);
				repeat (2) @(posedge pclk);
				tg = 0;
				lv = sck_o;
				for (int i = 0; i < 4 * HALF; i++) begin
					@(posedge pclk);
					chk({31'h0, sck_oe}, {31'h0, eo}, "clock pin enable");
					if (eo && ck == 0)
						chk({31'h0, sck_o}, {31'h0, el}, "clock pin level");
					if (sck_o !== lv)
						tg++;
					lv = sck_o;
				end
				if (eo)
					chk(tg, ck * 4, "clock pin toggles");
			end
		end
		$display("test clock pin done");
		chk(rd_q.size(), 32'h0, "answers seen");
		tally_and_finish();
	end
endmodule : smart_card_serial_control_bench
